// file: logic/nvsc_host.v
// Host controller driving a nonvolatile SRAM through its asynchronous strobes
// Functional notes
// - Host issues each sequence step as a chip-enable framed read.
// - Host reads the six sequence addresses back to back, in order.
// - Host holds write-enable high through all six sequence reads.
// - Host drives store_busy_n low at least 15 ns to request store.
// - Host keeps store_busy_n high during ordinary reads and writes.
`timescale 1ns/10ps
`include "nvsc_map.vh"
module nvsc_host #(
  parameter AW           = 15,
  parameter DW           = 8,
  parameter TW           = 32,
  parameter POWERUP_CYC  = `NVSC_POWERUP_CYC,
  parameter CMD_CYC      = `NVSC_CMD_CYC,
  parameter RECALL_CYC   = `NVSC_RECALL_CYC,
  parameter STOREOP_CYC  = `NVSC_STOREOP_CYC
) (
  input  wire                clk_in,
  input  wire                nrst_in,
  // User command port
  input  wire                req_valid_in,
  input  wire [2:0]          req_cmd_in,
  input  wire [AW-1:0]       req_addr_in,
  input  wire [DW-1:0]       req_wdata_in,
  input  wire                seq_recall_in,
  input  wire [6*AW-1:0]     seq_addrs_in,
  output wire                req_ready_out,
  output reg                 rsp_valid_out,
  output reg  [DW-1:0]       rsp_rdata_out,
  output wire                ready_out,
  // Memory pins
  output reg  [AW-1:0]       mem_addr_out,
  output reg                 mem_ce_n_out,
  output reg                 mem_we_n_out,
  output reg                 mem_oe_n_out,
  input  wire [DW-1:0]       mem_dq_in,
  output reg  [DW-1:0]       mem_dq_out,
  output reg                 mem_dq_oe_out,
  input  wire                store_busy_n_in,
  output reg                 store_busy_n_out,
  output reg                 store_busy_n_oe_out
);
  // =========================================================
  // States
  // =========================================================
  localparam [3:0] ST_PWRUP  = 4'h0;
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_RD     = 4'h2;
  localparam [3:0] ST_WR     = 4'h3;
  localparam [3:0] ST_SEQ    = 4'h4;
  localparam [3:0] ST_GAP    = 4'h5;
  localparam [3:0] ST_SEQWT  = 4'h6;
  localparam [3:0] ST_HSREQ  = 4'h7;
  localparam [3:0] ST_HSWT   = 4'h8;

  reg  [3:0]    st_q;
  reg  [2:0]    step_q;
  reg           recall_q;
  reg           dirty_q;
  reg           pu_arm_q;
  reg           busy_s1_q;
  reg           busy_s2_q;
  reg  [DW-1:0] dq_s1_q;
  reg  [DW-1:0] dq_s2_q;
  reg           tmr_load;
  reg  [TW-1:0] tmr_cnt;
  wire          tmr_done;

  // Picks one sequence address out of the packed list
  function [AW-1:0] seq_addr;
    input [6*AW-1:0] list;
    input [2:0]      idx;
    begin
      seq_addr = list[idx*AW +: AW];
    end
  endfunction

  // Widens a cycle count to the timer width
  function [TW-1:0] cyc;
    input integer n;
    begin
      cyc = n[TW-1:0];
    end
  endfunction

  nvsc_timer #(.WIDTH(TW)) u_tmr (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .load_in  (tmr_load),
    .count_in (tmr_cnt),
    .done_out (tmr_done)
  );

  // =========================================================
  // Pin synchronisers
  // =========================================================
  // Busy and data come from an unclocked device, so two stages first
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
      dq_s1_q   <= {DW{1'b0}};
      dq_s2_q   <= {DW{1'b0}};
    end else begin
      busy_s1_q <= store_busy_n_in;
      busy_s2_q <= busy_s1_q;
      dq_s1_q   <= mem_dq_in;
      dq_s2_q   <= dq_s1_q;
    end
  end

  assign ready_out     = (st_q == ST_IDLE);
  assign req_ready_out = ready_out && busy_s2_q;

  // =========================================================
  // Timer loads on state entry
  // =========================================================
  always @* begin
    tmr_load = 1'b0;
    tmr_cnt  = {TW{1'b0}};
    if (st_q == ST_IDLE && req_valid_in && busy_s2_q) begin
      tmr_load = 1'b1;
      case (req_cmd_in)
        `NVSC_CMD_WRITE:   tmr_cnt = cyc(`NVSC_WR_CYC);
        `NVSC_CMD_HWSTORE: tmr_cnt = cyc(`NVSC_STORE_CYC);
        default:           tmr_cnt = cyc(`NVSC_RD_CYC + 2);
      endcase
    end else if (st_q == ST_GAP && tmr_done) begin
      tmr_load = 1'b1;
      if (step_q == `NVSC_SEQ_LEN) begin
        // Wait out processing plus the operation; pins stay idle meanwhile
        tmr_cnt = cyc(CMD_CYC) + (recall_q ? cyc(RECALL_CYC) : cyc(STOREOP_CYC));
      end else begin
        tmr_cnt = cyc(`NVSC_RD_CYC + 2);
      end
    end else if (st_q == ST_HSREQ && tmr_done) begin
      tmr_load = 1'b1;
      // No write since last cycle means the device frees the pin quickly
      tmr_cnt  = dirty_q ? cyc(STOREOP_CYC) : cyc(`NVSC_RELEASE_CYC + 2);
    end else if (st_q == ST_PWRUP && !pu_arm_q) begin
      tmr_load = 1'b1;
      tmr_cnt  = cyc(POWERUP_CYC);
    end else if ((st_q == ST_RD || st_q == ST_SEQ || st_q == ST_WR) && tmr_done) begin
      tmr_load = 1'b1;
      tmr_cnt  = cyc(1);
    end
  end

  // =========================================================
  // Main sequencer
  // =========================================================
  // Power-up wait covers the restore time counted from supply good
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q                <= ST_PWRUP;
      step_q              <= 3'h0;
      recall_q            <= 1'b0;
      dirty_q             <= 1'b0;
      pu_arm_q            <= 1'b0;
      rsp_valid_out       <= 1'b0;
      rsp_rdata_out       <= {DW{1'b0}};
      mem_addr_out        <= {AW{1'b0}};
      mem_ce_n_out        <= 1'b1;
      mem_we_n_out        <= 1'b1;
      mem_oe_n_out        <= 1'b1;
      mem_dq_out          <= {DW{1'b0}};
      mem_dq_oe_out       <= 1'b0;
      store_busy_n_out    <= 1'b1;
      store_busy_n_oe_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (st_q)
        ST_PWRUP: begin
          // Accesses would be ignored until the restore ends
          pu_arm_q <= 1'b1;
          if (pu_arm_q && tmr_done && busy_s2_q) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // store_busy_n released during ordinary accesses
          store_busy_n_oe_out <= 1'b0;
          if (req_valid_in && busy_s2_q) begin
            mem_addr_out <= req_addr_in;
            case (req_cmd_in)
              `NVSC_CMD_WRITE: begin
                mem_ce_n_out  <= 1'b0;
                mem_we_n_out  <= 1'b0;
                mem_dq_out    <= req_wdata_in;
                mem_dq_oe_out <= 1'b1;
                dirty_q       <= 1'b1;
                st_q          <= ST_WR;
              end
              `NVSC_CMD_SEQ: begin
                recall_q     <= seq_recall_in;
                step_q       <= 3'h1;
                mem_addr_out <= seq_addr(seq_addrs_in, 3'h0);
                mem_ce_n_out <= 1'b0;
                mem_oe_n_out <= 1'b0;
                mem_we_n_out <= 1'b1;
                st_q         <= ST_SEQ;
              end
              `NVSC_CMD_HWSTORE: begin
                store_busy_n_out    <= 1'b0;
                store_busy_n_oe_out <= 1'b1;
                st_q                <= ST_HSREQ;
              end
              default: begin
                mem_ce_n_out <= 1'b0;
                mem_oe_n_out <= 1'b0;
                st_q         <= ST_RD;
              end
            endcase
          end
        end
        ST_RD: begin
          if (tmr_done) begin
            rsp_valid_out <= 1'b1;
            rsp_rdata_out <= dq_s2_q;
            mem_ce_n_out  <= 1'b1;
            mem_oe_n_out  <= 1'b1;
            st_q          <= ST_GAP;
          end
        end
        ST_WR: begin
          if (tmr_done) begin
            mem_we_n_out  <= 1'b1;
            mem_ce_n_out  <= 1'b1;
            mem_dq_oe_out <= 1'b0;
            st_q          <= ST_GAP;
          end
        end
        ST_SEQ: begin
          // Sixth read data is never returned to the user
          if (tmr_done) begin
            mem_ce_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            st_q         <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Two idle cycles between reads keep the sequence back to back
          if (tmr_done) begin
            if (step_q == 3'h0) begin
              st_q <= ST_IDLE;
            end else if (step_q == `NVSC_SEQ_LEN) begin
              step_q <= 3'h0;
              st_q   <= ST_SEQWT;
            end else begin
              mem_addr_out <= seq_addr(seq_addrs_in, step_q);
              mem_ce_n_out <= 1'b0;
              mem_oe_n_out <= 1'b0;
              step_q       <= step_q + 3'h1;
              st_q         <= ST_SEQ;
            end
          end
        end
        ST_SEQWT: begin
          // Pins kept idle until the locked-out operation ends
          if (tmr_done) begin
            dirty_q <= 1'b0;
            st_q    <= ST_IDLE;
          end
        end
        ST_HSREQ: begin
          if (tmr_done) begin
            store_busy_n_out    <= 1'b1;
            store_busy_n_oe_out <= 1'b0;
            st_q                <= ST_HSWT;
          end
        end
        ST_HSWT: begin
          // Device drives busy low while it stores; wait for its release
          if (tmr_done && busy_s2_q) begin
            dirty_q <= 1'b0;
            st_q    <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: logic/nvsc_map.vh
// Timing counts, command codes and sequence step count for the nonvolatile SRAM host controller
`ifndef NVSC_MAP_VH
`define NVSC_MAP_VH

// Clock period in picoseconds (40 MHz)
`define NVSC_CLK_PS          25000
// Write-cycle low strobe time in ns
`define NVSC_WR_PULSE_NS     20
// Read cycle time in ns
`define NVSC_RD_CYCLE_NS     25
// Least store request pulse on store_busy_n in ns
`define NVSC_STORE_PULSE_NS  15
// Longest time the device may need to answer a request with no store, in ns
`define NVSC_BUSY_RELEASE_NS 25
// Command processing time in us
`define NVSC_CMD_PROC_US     100
// Power-up restore time in ms
`define NVSC_POWERUP_MS      20
// Software recall duration in us
`define NVSC_RECALL_US       200
// Store duration in ms
`define NVSC_STORE_MS        8

// Cycle counts derived from the times, least times rounded up
`define NVSC_CYC_UP(ps) (((ps) + `NVSC_CLK_PS - 1) / `NVSC_CLK_PS)
`define NVSC_WR_CYC      `NVSC_CYC_UP(`NVSC_WR_PULSE_NS * 1000)
`define NVSC_RD_CYC      `NVSC_CYC_UP(`NVSC_RD_CYCLE_NS * 1000)
`define NVSC_STORE_CYC   `NVSC_CYC_UP(`NVSC_STORE_PULSE_NS * 1000)
`define NVSC_RELEASE_CYC `NVSC_CYC_UP(`NVSC_BUSY_RELEASE_NS * 1000)
`define NVSC_CMD_CYC     `NVSC_CYC_UP(`NVSC_CMD_PROC_US * 1000000)
// Millisecond waits go through cycles per microsecond; picoseconds would overflow 32 bits
`define NVSC_CYC_PER_US  (1000000 / `NVSC_CLK_PS)
`define NVSC_POWERUP_CYC (`NVSC_POWERUP_MS * 1000 * `NVSC_CYC_PER_US)
`define NVSC_RECALL_CYC  `NVSC_CYC_UP(`NVSC_RECALL_US * 1000000)
`define NVSC_STOREOP_CYC (`NVSC_STORE_MS * 1000 * `NVSC_CYC_PER_US)

// Host command codes
`define NVSC_CMD_READ    3'h0
`define NVSC_CMD_WRITE   3'h1
`define NVSC_CMD_SEQ     3'h2
`define NVSC_CMD_HWSTORE 3'h3

// Sequence step count
`define NVSC_SEQ_LEN     3'h6

`endif

// file: logic/nvsc_timer.v
// Down-counter used to time strobes and waits in the host controller
`timescale 1ns/10ps
module nvsc_timer #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  input  wire             load_in,
  input  wire [WIDTH-1:0] count_in,
  output wire             done_out
);
  reg [WIDTH-1:0] cnt_q;
  reg [WIDTH-1:0] cnt_d;

  // =========================================================
  // Counter
  // =========================================================
  // Load wins over counting so a new wait always restarts cleanly
  always @* begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = count_in;
    end else if (cnt_q != {WIDTH{1'b0}}) begin
      cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= {WIDTH{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Plain compare: gating with the load would close a loop through the sequencer
  assign done_out = (cnt_q == {WIDTH{1'b0}});
endmodule

// file: testbench/nvsc_host_asserts.sv
// Pin-level checks for the nonvolatile SRAM host controller
`timescale 1ns/10ps
module nvsc_host_asserts #(
  parameter AW = 15
) (
  input logic          clk_in,
  input logic          nrst_in,
  input logic [AW-1:0] mem_addr_out,
  input logic          mem_ce_n_out,
  input logic          mem_we_n_out,
  input logic          mem_oe_n_out,
  input logic          mem_dq_oe_out,
  input logic          store_busy_n_in,
  input logic          store_busy_n_out,
  input logic          store_busy_n_oe_out,
  input logic          req_ready_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========
  // Strobe relations; address must not move under an open access
  property p_dq_wr; mem_dq_oe_out |-> !mem_ce_n_out && !mem_we_n_out; endproperty
  a_dq_wr: assert property (p_dq_wr) else $error("data out of write");
  property p_rd_we; !mem_ce_n_out && !mem_oe_n_out |-> mem_we_n_out; endproperty
  a_rd_we: assert property (p_rd_we) else $error("write strobe in read");
  property p_oe_ce; !mem_oe_n_out |-> !mem_ce_n_out; endproperty
  a_oe_ce: assert property (p_oe_ce) else $error("read not chip framed");
  property p_we_len; $fell(mem_we_n_out) |=> !mem_we_n_out ##1 mem_we_n_out; endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse length");
  property p_addr; !mem_ce_n_out && !$past(mem_ce_n_out) |-> $stable(mem_addr_out); endproperty
  a_addr: assert property (p_addr) else $error("address moved in access");
  // ==========
  // Busy pin: driven only low and never during an access
  property p_hsb; store_busy_n_oe_out |-> !store_busy_n_out && mem_ce_n_out; endproperty
  a_hsb: assert property (p_hsb) else $error("busy pin misuse");
  property p_busy_rdy; !store_busy_n_in [*4] |-> !req_ready_out; endproperty
  a_busy_rdy: assert property (p_busy_rdy) else $error("ready while busy");
  property p_lock; !store_busy_n_in [*4] |-> mem_ce_n_out; endproperty
  a_lock: assert property (p_lock) else $error("access while busy");
endmodule
bind nvsc_host nvsc_host_asserts #(.AW(AW)) u_nvsc_host_asserts (.*);

// file: testbench/nvsc_dev_model.sv
// Behavioural model of the nonvolatile SRAM behind the host controller
`timescale 1ns/10ps
module nvsc_dev_model #(
  parameter [89:0] SEQ_ST = 90'h0,
  parameter [89:0] SEQ_RC = 90'h0,
  parameter        PU_NS  = 600,
  parameter        ST_NS  = 400,
  parameter        RC_NS  = 300
) (
  input  wire        vcc_ok_in,
  input  wire [14:0] addr_in,
  input  wire        ce_n_in,
  input  wire        we_n_in,
  input  wire        oe_n_in,
  input  wire [7:0]  dq_in,
  output wire [7:0]  dq_out,
  output wire        dq_oe_out,
  input  wire        busy_n_in,
  output reg         busy_n_drv_out = 1'b1
);
  // Fixed arrays keep the continuous read below legal for every tool
  logic [7:0] sram [0:32767];
  logic [7:0] nv   [0:32767];
  reg   [7:0] last_q = 8'h00;
  reg         lock = 1'b1;
  reg         dirty = 1'b0;
  integer     idx = 0;
  wire        rd_pin = !ce_n_in && we_n_in && !oe_n_in;
  wire        rd = rd_pin && !lock;
  wire        wr = !ce_n_in && !we_n_in;
  // ==========
  // Released bus shows the inverse of the last byte so stale data never passes
  assign dq_oe_out = rd;
  assign dq_out = rd ? sram[addr_in] : ~last_q;
  always @* if (rd) last_q = sram[addr_in];
  // Store or recall; the lock lands only after the grace time for a pending write
  task run(input rc);
    begin
      idx = 0;
      #25 lock = 1'b1;
      busy_n_drv_out = 1'b0;
      #(rc ? RC_NS : ST_NS);
      if (rc) sram = nv; else nv = sram;
      dirty = 1'b0;
      busy_n_drv_out = 1'b1;
      lock = 1'b0;
    end
  endtask
  // Commit in mid-pulse, clear of the edge where the host drops its strobes
  always @(posedge wr) begin
    idx = 0;
    #10;
    if (wr && !lock) begin
      sram[addr_in] = dq_in;
      dirty = 1'b1;
    end
  end
  // Command sequence tracking; any stray read restarts it
  always @(posedge rd_pin) begin
    #5;
    if (!lock) begin
      if (idx == 5 && addr_in == SEQ_RC[75 +: 15]) run(1'b1);
      else if (addr_in == SEQ_ST[idx*15 +: 15]) idx = idx + 1;
      else idx = (addr_in == SEQ_ST[14:0]) ? 1 : 0;
      if (idx == 6) run(1'b0);
    end
  end
  // Pin store request; a clean part leaves the pin to its pull-up at once
  // A request pulse shorter than the least width is not taken
  always @(negedge busy_n_in) if (busy_n_drv_out && !lock) begin
    #15;
    if (dirty && !busy_n_in) run(1'b0);
  end
  // Supply: store on loss if dirty, restore timed from the trigger crossing
  always @(vcc_ok_in) begin
    lock = 1'b1;
    if (!vcc_ok_in && dirty) nv = sram;
    dirty = 1'b0;
    if (vcc_ok_in) begin
      busy_n_drv_out = 1'b0;
      #PU_NS sram = nv;
      busy_n_drv_out = 1'b1;
      lock = 1'b0;
    end
  end
endmodule

// file: testbench/nvsc_host_test.sv
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module nvsc_host_test;
  localparam [89:0] SQ_ST = {15'h0c0c, 15'h3333, 15'h0f0f, 15'h1c1c, 15'h2a2a, 15'h0e38};
  localparam [89:0] SQ_RC = {15'h0c63, SQ_ST[74:0]};
  reg clk_in = 0, nrst_in = 0, req_valid_in = 0, seq_recall_in = 0, vcc_ok = 0;
  reg [2:0] req_cmd_in = 0;
  reg [14:0] req_addr_in = 0;
  reg [7:0] req_wdata_in = 0, got;
  reg [89:0] seq_addrs_in = 0;
  reg [14:0] a[0:7];
  wire rq_rdy, rsp_v, rdy, ce_n, we_n, oe_n, dq_oe, bsy_o, bsy_oe, dev_oe, dev_bsy;
  wire [7:0] rdata, dq_o, dev_dq;
  wire [14:0] addr;
  integer err_count = 0, cmp_count = 0, cyc;
  logic [7:0] sm[int], nvm[int];
  // Resolved pins: busy is pulled up and pulled low by either party
  wire [7:0] dq = dq_oe ? dq_o : dev_dq;
  wire bsy = !(bsy_oe && !bsy_o) && dev_bsy;
  nvsc_host #(.POWERUP_CYC(20), .CMD_CYC(20), .RECALL_CYC(20), .STOREOP_CYC(20)) u_nvsc_host (
    .clk_in(clk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .seq_recall_in(seq_recall_in),
    .seq_addrs_in(seq_addrs_in), .req_ready_out(rq_rdy), .rsp_valid_out(rsp_v),
    .rsp_rdata_out(rdata), .ready_out(rdy), .mem_addr_out(addr), .mem_ce_n_out(ce_n),
    .mem_we_n_out(we_n), .mem_oe_n_out(oe_n), .mem_dq_in(dq), .mem_dq_out(dq_o),
    .mem_dq_oe_out(dq_oe), .store_busy_n_in(bsy), .store_busy_n_out(bsy_o),
    .store_busy_n_oe_out(bsy_oe));
  nvsc_dev_model #(.SEQ_ST(SQ_ST), .SEQ_RC(SQ_RC)) u_nvsc_dev_model (.vcc_ok_in(vcc_ok),
    .addr_in(addr), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .dq_in(dq),
    .dq_out(dev_dq), .dq_oe_out(dev_oe), .busy_n_in(bsy), .busy_n_drv_out(dev_bsy));
  // ==========
  // Bus tasks; every wait is bounded so a hang shows as a mismatch
  initial forever #12.5 clk_in = ~clk_in;
  // While the host drives data the part must keep its outputs off
  always @(negedge clk_in) if (dq_oe === 1'b1) `CHK("dq_drive", 1'b0, dev_oe)
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task wait_rdy;
    begin
      cyc = 0;
      @(negedge clk_in);
      while (rq_rdy !== 1'b1 && cyc < 400) begin
        @(negedge clk_in);
        cyc++;
      end
      `CHK("ready", 1'b1, rq_rdy)
      `CHK("ready_out", 1'b1, rdy)
    end
  endtask
  task req(input [2:0] c, input [14:0] ad, input [7:0] d);
    begin
      req_cmd_in = c;
      req_addr_in = ad;
      req_wdata_in = d;
      req_valid_in = 1;
      @(negedge clk_in) req_valid_in = 0;
      for (cyc = 0; c == 0 && rsp_v !== 1'b1 && cyc < 20; cyc++) @(negedge clk_in);
      if (c == 0) `CHK("rsp_valid", 1'b1, rsp_v)
      got = rdata;
      wait_rdy;
    end
  endtask
  task rd_chk(input [14:0] ad);
    begin
      req(0, ad, 0);
      `CHK("rdata", sm[ad], got)
    end
  endtask
  task seq(input rc, input [89:0] l);
    begin
      seq_recall_in = rc;
      seq_addrs_in = l;
      req(2, 0, 0);
    end
  endtask
  // Watchdog of 8000 cycles, well above the few hundred cycles the tests need
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
  // Main sequence: power-up, random traffic, pin and command stores and recalls
  initial begin
    got = $urandom(32'hef5a);
    #100 vcc_ok = 1;
    repeat (12) @(negedge clk_in);
    nrst_in = 1;
    @(negedge clk_in);
    `CHK("ready_pu", 1'b0, rq_rdy)
    wait_rdy;
    `CHK("pu_wait", 1'b1, $time >= 700)
    for (int i = 0; i < 8; i++) begin
      a[i] = i == 0 ? 15'h0 : i == 1 ? 15'h7fff : 15'($urandom);
      sm[a[i]] = 8'($urandom);
      req(1, a[i], sm[a[i]]);
    end
    for (int i = 0; i < 8; i++) rd_chk(a[i]);
    req(3, 0, 0);
    `CHK("st_long", 1'b1, cyc >= 16)
    nvm = sm;
    sm[a[0]] = ~sm[a[0]];
    req(1, a[0], sm[a[0]]);
    seq(1'b1, SQ_RC);
    sm = nvm;
    rd_chk(a[0]);
    req(3, 0, 0);
    `CHK("st_skip", 1'b1, cyc <= 8)
    sm[a[1]] = 8'($urandom);
    req(1, a[1], sm[a[1]]);
    seq(1'b0, SQ_ST);
    nvm = sm;
    sm[a[1]] = ~sm[a[1]];
    req(1, a[1], sm[a[1]]);
    seq(1'b1, {SQ_RC[89:30], SQ_RC[14:0], SQ_RC[29:15]});
    rd_chk(a[1]);
    seq(1'b1, SQ_RC);
    sm = nvm;
    rd_chk(a[1]);
    end_of_test;
  end
endmodule
